// ### rtl/pump_command_interpreter.sv
`timescale 1ns/100ps
module pump_command_interpreter
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] valve_port_count,
	input wire logic plunger_stall,
	input wire logic motion_done,
	output logic plunger_up_r,
	output logic plunger_back_go_r,
	output logic valve_home_go_r,
	output logic position_zero_r,
	output logic valve_ccw_r,
	output logic [1:0] home_force_r,
	output logic [5:0] home_speed_code_r,
	output logic [9:0] home_pps_r,
	output logic [3:0] in_port_r,
	output logic [3:0] out_port_r,
	output logic [12:0] backoff_steps_r,
	output logic [12:0] backlash_steps_r,
	output logic [1:0] step_mode_r,
	output logic [9:0] rate_limit_r,
	output logic nv_we_r,
	output logic [4:0] nv_addr_r,
	output logic [7:0] nv_wdata_r,
	output logic busy_r
);
	import pump_cmd_pkg::*;

	// ************************************************************
	// apb slave
	// ************************************************************
	logic acc_done;
	logic chr_wr;
	logic [7:0] chr;
	logic reply_clr;
	logic mapped;
	logic [31:0] rd_val;
	logic [3:0] err_r;
	logic reply_r;
	logic buffered_r;
	logic nv_auto_r;
	logic nv_baud_r;

	assign acc_done = psel & penable & pready;
	assign chr_wr = acc_done & pwrite & (paddr == OFF_CHAR);
	assign chr = pwdata[7:0];
	assign reply_clr = acc_done & pwrite & (paddr == OFF_STATUS) & pwdata[STS_REPLY_BIT];

	always_comb
	begin
		rd_val = 32'h0000_0000;
		mapped = 1'b1;
		if (paddr == OFF_CHAR)
		begin
			rd_val = 32'h0000_0000;
		end
		else if (paddr == OFF_STATUS)
		begin
			// status char: 0x40 base, ready bit, error code
			rd_val[STS_ERR_LSB +: 4] = err_r;
			rd_val[STS_READY_BIT] = ~busy_r;
			rd_val[STS_STATUS_CHAR_BIT] = 1'b1;
			rd_val[STS_REPLY_BIT] = reply_r;
			rd_val[STS_BUFFERED_BIT] = buffered_r;
			rd_val[STS_HOST_ADDR_LSB +: 8] = CH_HOST_ADDR;
		end
		else if (paddr == OFF_SETTINGS)
		begin
			rd_val[1:0] = step_mode_r;
			rd_val[SET_AUTO_BIT] = nv_auto_r;
			rd_val[SET_BAUD_BIT] = nv_baud_r;
			rd_val[SET_CCW_BIT] = valve_ccw_r;
			rd_val[SET_FORCE_LSB +: 2] = home_force_r;
			rd_val[SET_LIMIT_LSB +: 10] = rate_limit_r;
		end
		else if (paddr == OFF_STEPS)
		begin
			rd_val[12:0] = backlash_steps_r;
			rd_val[STEPS_OFFSET_LSB +: 13] = backoff_steps_r;
		end
		else if (paddr == OFF_PORTS)
		begin
			rd_val[3:0] = in_port_r;
			rd_val[PORTS_OUT_LSB +: 4] = out_port_r;
			rd_val[PORTS_SPEED_LSB +: 6] = home_speed_code_r;
			rd_val[PORTS_PPS_LSB +: 10] = home_pps_r;
		end
		else
		begin
			mapped = 1'b0;
		end
	end

	// no wait state: pready rises in the first access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel & ~penable;
			// error stands only beside pready, never after the transfer
			pslverr <= psel & ~penable & ~mapped;
			if (psel & ~penable)
			begin
				prdata <= pwrite ? 32'h0000_0000 : rd_val;
			end
		end
	end

	// ************************************************************
	// receive side: buffer fill, execute request, refusal
	// ************************************************************
	exec_state_e st_r;
	logic [7:0] wr_ptr_r;
	logic [7:0] first_r;
	logic has_exec_r;
	logic [7:0] len_r;
	logic go;
	logic term;
	logic rx_err;
	logic [3:0] rx_code;
	logic mem_we;

	assign mem_we = chr_wr & ~busy_r & (chr != CH_CR) & (wr_ptr_r != BUF_LAST);
	assign go = chr_wr & ~busy_r & (chr == CH_CR) & (has_exec_r | first_r == CMD_QUERY);
	assign term = chr_wr & busy_r & (chr == CH_CR) & (first_r == CMD_TERM);

	always_comb
	begin
		rx_err = 1'b0;
		rx_code = ERR_NONE;
		if (chr_wr & busy_r & (chr == CH_CR) & (wr_ptr_r != 8'h00))
		begin
			if (first_r != CMD_TERM && first_r != CMD_QUERY)
			begin
				rx_err = 1'b1;
				rx_code = ERR_BUSY;
			end
		end
		else if (chr_wr & ~busy_r & (chr != CH_CR) & (wr_ptr_r == BUF_LAST))
		begin
			rx_err = 1'b1;
			rx_code = ERR_OVERFLOW;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wr_ptr_r <= 8'h00;
			first_r <= CMD_NONE;
			has_exec_r <= 1'b0;
			buffered_r <= 1'b0;
			len_r <= 8'h00;
		end
		else if (chr_wr)
		begin
			if (chr == CH_CR)
			begin
				wr_ptr_r <= 8'h00;
				has_exec_r <= 1'b0;
				first_r <= CMD_NONE;
				if (!busy_r)
				begin
					len_r <= wr_ptr_r;
					buffered_r <= ~go & (wr_ptr_r != 8'h00);
				end
			end
			else if (wr_ptr_r != BUF_LAST)
			begin
				// counting goes on while busy so the first char is known
				wr_ptr_r <= wr_ptr_r + 8'h01;
				if (wr_ptr_r == 8'h00)
				begin
					first_r <= chr;
					if (!busy_r)
					begin
						buffered_r <= 1'b0;
					end
				end
				if (chr == CMD_EXEC)
				begin
					has_exec_r <= 1'b1;
				end
			end
		end
	end

	// reply pending flag, set wins over software clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			reply_r <= 1'b0;
		end
		else if (chr_wr & (chr == CH_CR))
		begin
			reply_r <= 1'b1;
		end
		else if (reply_clr)
		begin
			reply_r <= 1'b0;
		end
	end

	// ************************************************************
	// execution: walk the buffer and parse
	// ************************************************************
	logic [7:0] idx_r;
	logic [7:0] rd_data;
	logic [7:0] cmd_r;
	logic [15:0] par_r [0:2];
	logic [1:0] pi_r;
	logic bad_r;
	logic at_end;
	logic is_digit;
	logic [15:0] par_nxt;
	logic ap_err;
	logic [3:0] ap_code;
	logic [15:0] lim;
	logic [15:0] nports;
	logic apply_ok;

	cmd_buffer_mem u_buf
	(
		.pclk(pclk),
		.we(mem_we),
		.waddr(wr_ptr_r),
		.wdata(chr),
		.raddr(idx_r),
		.rdata(rd_data)
	);

	assign at_end = (idx_r == len_r);
	assign is_digit = (rd_data >= CH_ZERO) && (rd_data <= CH_NINE);
	assign par_nxt = (par_r[pi_r] << 3) + (par_r[pi_r] << 1) + {8'h00, rd_data - CH_ZERO};
	assign lim = (step_mode_r == 2'h0) ? STEPS_MAX_NORMAL : STEPS_MAX_FINE;
	assign nports = {12'h000, valve_port_count};
	assign apply_ok = (st_r == ST_APPLY) & ~ap_err;

	// validation of the pending command against its ranges
	always_comb
	begin
		ap_err = bad_r;
		ap_code = ERR_BAD_PAR;
		if (cmd_r == CMD_STEP_MODE)
		begin
			ap_err = bad_r | (par_r[0] > MODE_MAX);
		end
		else if (cmd_r == CMD_BACKLASH || cmd_r == CMD_OFFSET)
		begin
			ap_err = bad_r | (par_r[0] > lim);
		end
		else if (cmd_r == CMD_USER_DATA)
		begin
			ap_err = bad_r | (par_r[0] > USER_LOC_MAX) | (par_r[1] > USER_DATA_MAX);
		end
		else if (cmd_r == CMD_NV_CFG)
		begin
			ap_err = bad_r | ~(par_r[0] == NV_AUTO_SET || par_r[0] == NV_AUTO_CLR ||
				par_r[0] == NV_BAUD_9600 || par_r[0] == NV_BAUD_38400);
		end
		else if (cmd_r == CMD_INIT_CW || cmd_r == CMD_INIT_CCW)
		begin
			ap_err = bad_r | (par_r[0] > FORCE_MAX && (par_r[0] < SPEED_CODE_MIN || par_r[0] > SPEED_CODE_MAX))
				| (par_r[1] > nports) | (par_r[2] > nports);
		end
		else if (cmd_r != CMD_EXEC && cmd_r != CMD_QUERY && cmd_r != CMD_TERM)
		begin
			ap_err = 1'b1;
			ap_code = ERR_BAD_CMD;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_r <= ST_IDLE;
			idx_r <= 8'h00;
			cmd_r <= CMD_NONE;
			par_r[0] <= 16'h0000;
			par_r[1] <= 16'h0000;
			par_r[2] <= 16'h0000;
			pi_r <= 2'h0;
			bad_r <= 1'b0;
		end
		else if (term)
		begin
			st_r <= ST_IDLE;
		end
		else
		begin
			case (st_r)
				ST_IDLE:
				begin
					idx_r <= 8'h00;
					cmd_r <= CMD_NONE;
					pi_r <= 2'h0;
					bad_r <= 1'b0;
					par_r[0] <= 16'h0000;
					par_r[1] <= 16'h0000;
					par_r[2] <= 16'h0000;
					if (go)
					begin
						st_r <= ST_RD;
					end
				end
				ST_RD:
				begin
					st_r <= ST_CH;
				end
				ST_CH:
				begin
					if (!at_end && is_digit && cmd_r != CMD_NONE)
					begin
						par_r[pi_r] <= par_nxt;
						bad_r <= bad_r | (par_r[pi_r] > PAR_SAT);
						idx_r <= idx_r + 8'h01;
						st_r <= ST_RD;
					end
					else if (!at_end && rd_data == CH_COMMA && cmd_r != CMD_NONE)
					begin
						bad_r <= bad_r | (pi_r == 2'h2);
						pi_r <= (pi_r == 2'h2) ? pi_r : pi_r + 2'h1;
						idx_r <= idx_r + 8'h01;
						st_r <= ST_RD;
					end
					else if (cmd_r != CMD_NONE)
					begin
						st_r <= ST_APPLY;
					end
					else if (at_end)
					begin
						st_r <= ST_IDLE;
					end
					else
					begin
						cmd_r <= rd_data;
						idx_r <= idx_r + 8'h01;
						st_r <= ST_RD;
					end
				end
				ST_APPLY:
				begin
					cmd_r <= CMD_NONE;
					pi_r <= 2'h0;
					bad_r <= 1'b0;
					par_r[0] <= 16'h0000;
					par_r[1] <= 16'h0000;
					par_r[2] <= 16'h0000;
					// an error abandons the rest of the string
					if (ap_err)
					begin
						st_r <= ST_IDLE;
					end
					else if (cmd_r == CMD_INIT_CW || cmd_r == CMD_INIT_CCW)
					begin
						st_r <= ST_UP;
					end
					else
					begin
						st_r <= ST_RD;
					end
				end
				ST_UP:
				begin
					if (plunger_stall)
					begin
						st_r <= ST_BACK;
					end
				end
				ST_BACK:
				begin
					if (motion_done)
					begin
						st_r <= ST_VALVE;
					end
				end
				ST_VALVE:
				begin
					if (motion_done)
					begin
						st_r <= ST_RD;
					end
				end
				default:
				begin
					st_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// homing strobes towards the drives
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			plunger_up_r <= 1'b0;
			plunger_back_go_r <= 1'b0;
			valve_home_go_r <= 1'b0;
			position_zero_r <= 1'b0;
			busy_r <= 1'b0;
		end
		else
		begin
			busy_r <= ~term & ((st_r != ST_IDLE) | go);
			plunger_up_r <= ~term & ((apply_ok & (cmd_r == CMD_INIT_CW || cmd_r == CMD_INIT_CCW)) |
				(st_r == ST_UP & ~plunger_stall));
			plunger_back_go_r <= ~term & (st_r == ST_UP) & plunger_stall;
			valve_home_go_r <= ~term & (st_r == ST_BACK) & motion_done;
			position_zero_r <= ~term & (st_r == ST_VALVE) & motion_done;
		end
	end

	// ************************************************************
	// settings written by executed commands
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			step_mode_r <= 2'h0;
			backlash_steps_r <= BACKLASH_DEF_NORMAL;
			backoff_steps_r <= OFFSET_DEF;
			valve_ccw_r <= 1'b0;
			home_force_r <= 2'h0;
			home_speed_code_r <= 6'h00;
			home_pps_r <= INIT_DEFAULT_PPS;
			in_port_r <= 4'h1;
			out_port_r <= 4'h0;
			nv_auto_r <= 1'b0;
			nv_baud_r <= 1'b0;
		end
		else if (apply_ok)
		begin
			if (cmd_r == CMD_STEP_MODE)
			begin
				step_mode_r <= par_r[0][1:0];
				backlash_steps_r <= (par_r[0] == 16'h0000) ? BACKLASH_DEF_NORMAL : BACKLASH_DEF_FINE;
			end
			else if (cmd_r == CMD_BACKLASH)
			begin
				backlash_steps_r <= par_r[0][12:0];
			end
			else if (cmd_r == CMD_OFFSET)
			begin
				backoff_steps_r <= par_r[0][12:0];
			end
			else if (cmd_r == CMD_NV_CFG)
			begin
				// pending copies only; the live link keeps its rate until power-up
				if (par_r[0] == NV_AUTO_SET || par_r[0] == NV_AUTO_CLR)
				begin
					nv_auto_r <= (par_r[0] == NV_AUTO_SET);
				end
				else
				begin
					nv_baud_r <= (par_r[0] == NV_BAUD_38400);
				end
			end
			else if (cmd_r == CMD_INIT_CW || cmd_r == CMD_INIT_CCW)
			begin
				valve_ccw_r <= (cmd_r == CMD_INIT_CCW);
				home_force_r <= (par_r[0] > FORCE_MAX) ? 2'h0 : par_r[0][1:0];
				home_speed_code_r <= (par_r[0] > FORCE_MAX) ? par_r[0][5:0] : 6'h00;
				home_pps_r <= (par_r[0] > FORCE_MAX) ? 10'h000 : INIT_DEFAULT_PPS;
				in_port_r <= (par_r[1] == 16'h0000) ? 4'h1 : par_r[1][3:0];
				out_port_r <= (par_r[2] == 16'h0000) ? valve_port_count : par_r[2][3:0];
				step_mode_r <= 2'h0;
				backlash_steps_r <= BACKLASH_DEF_NORMAL;
			end
		end
	end

	// fine mode caps cutoff and on-the-fly velocity, zero means no cap
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rate_limit_r <= 10'h000;
		end
		else
		begin
			rate_limit_r <= (step_mode_r == MODE_FINE) ? FINE_RATE_LIMIT : 10'h000;
		end
	end

	// ************************************************************
	// nonvolatile writes and error code
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			nv_we_r <= 1'b0;
			nv_addr_r <= 5'h00;
			nv_wdata_r <= 8'h00;
		end
		else
		begin
			nv_we_r <= apply_ok & (cmd_r == CMD_USER_DATA || cmd_r == CMD_NV_CFG);
			if (apply_ok & (cmd_r == CMD_USER_DATA))
			begin
				nv_addr_r <= par_r[0][4:0];
				nv_wdata_r <= par_r[1][7:0];
			end
			else if (apply_ok & (cmd_r == CMD_NV_CFG))
			begin
				nv_addr_r <= NV_CFG_ADDR;
				nv_wdata_r <= par_r[0][7:0];
			end
		end
	end

	// a new executed string starts clean; errors win over that clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			err_r <= ERR_NONE;
		end
		else if ((st_r == ST_APPLY) & ap_err)
		begin
			err_r <= ap_code;
		end
		else if (rx_err)
		begin
			err_r <= rx_code;
		end
		else if (go & (first_r != CMD_QUERY))
		begin
			// a query reports the last error, so it must not clear it
			err_r <= ERR_NONE;
		end
	end
endmodule : pump_command_interpreter

// ### rtl/pump_cmd_pkg.sv
package pump_cmd_pkg;
	// ************************************************************
	// register map (byte addresses on apb)
	// ************************************************************
	localparam logic [7:0] OFF_CHAR = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_SETTINGS = 8'h08;
	localparam logic [7:0] OFF_STEPS = 8'h0c;
	localparam logic [7:0] OFF_PORTS = 8'h10;
	localparam int STS_ERR_LSB = 0;
	localparam int STS_READY_BIT = 5;
	localparam int STS_STATUS_CHAR_BIT = 6;
	localparam int STS_REPLY_BIT = 8;
	localparam int STS_BUFFERED_BIT = 9;
	localparam int STS_HOST_ADDR_LSB = 16;
	localparam int SET_AUTO_BIT = 2;
	localparam int SET_BAUD_BIT = 3;
	localparam int SET_CCW_BIT = 4;
	localparam int SET_FORCE_LSB = 5;
	localparam int SET_LIMIT_LSB = 16;
	localparam int STEPS_OFFSET_LSB = 16;
	localparam int PORTS_OUT_LSB = 4;
	localparam int PORTS_SPEED_LSB = 8;
	localparam int PORTS_PPS_LSB = 16;
	// ************************************************************
	// characters
	// ************************************************************
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_COMMA = 8'h2c;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;
	localparam logic [7:0] CH_HOST_ADDR = 8'h30;
	localparam logic [7:0] CMD_NONE = 8'h00;
	localparam logic [7:0] CMD_EXEC = 8'h52;
	localparam logic [7:0] CMD_QUERY = 8'h51;
	localparam logic [7:0] CMD_TERM = 8'h54;
	localparam logic [7:0] CMD_STEP_MODE = 8'h4e;
	localparam logic [7:0] CMD_BACKLASH = 8'h4b;
	localparam logic [7:0] CMD_USER_DATA = 8'h3e;
	localparam logic [7:0] CMD_NV_CFG = 8'h55;
	localparam logic [7:0] CMD_OFFSET = 8'h6b;
	localparam logic [7:0] CMD_INIT_CW = 8'h5a;
	localparam logic [7:0] CMD_INIT_CCW = 8'h59;
	// ************************************************************
	// limits, defaults, codes
	// ************************************************************
	localparam logic [7:0] BUF_LAST = 8'hff;
	localparam logic [15:0] PAR_SAT = 16'h1999;
	localparam logic [15:0] MODE_MAX = 16'h0002;
	localparam logic [15:0] STEPS_MAX_NORMAL = 16'h0320;
	localparam logic [15:0] STEPS_MAX_FINE = 16'h1900;
	localparam logic [12:0] BACKLASH_DEF_NORMAL = 13'h000c;
	localparam logic [12:0] BACKLASH_DEF_FINE = 13'h0060;
	localparam logic [12:0] OFFSET_DEF = 13'h0000;
	localparam logic [15:0] USER_LOC_MAX = 16'h000f;
	localparam logic [15:0] USER_DATA_MAX = 16'h00ff;
	localparam logic [15:0] NV_AUTO_SET = 16'h001e;
	localparam logic [15:0] NV_AUTO_CLR = 16'h001f;
	localparam logic [15:0] NV_BAUD_9600 = 16'h0029;
	localparam logic [15:0] NV_BAUD_38400 = 16'h002f;
	localparam logic [4:0] NV_CFG_ADDR = 5'h10;
	localparam logic [15:0] FORCE_MAX = 16'h0002;
	localparam logic [15:0] SPEED_CODE_MIN = 16'h000a;
	localparam logic [15:0] SPEED_CODE_MAX = 16'h0028;
	localparam logic [9:0] INIT_DEFAULT_PPS = 10'h1f4;
	localparam logic [9:0] FINE_RATE_LIMIT = 10'h2ee;
	localparam logic [1:0] MODE_FINE = 2'h1;
	localparam logic [3:0] ERR_NONE = 4'h0;
	localparam logic [3:0] ERR_BAD_CMD = 4'h2;
	localparam logic [3:0] ERR_BAD_PAR = 4'h3;
	localparam logic [3:0] ERR_BUSY = 4'hf;
	localparam logic [3:0] ERR_OVERFLOW = 4'he;
	typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_CH, ST_APPLY, ST_UP, ST_BACK, ST_VALVE} exec_state_e;
endpackage : pump_cmd_pkg

// ### rtl/cmd_buffer_mem.sv
`timescale 1ns/100ps
// command character store: synchronous write, registered read
module cmd_buffer_mem
(
	input wire logic pclk,
	input wire logic we,
	input wire logic [7:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:255];

	// no reset: contents are only read below the stored length
	always_ff @(posedge pclk)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : cmd_buffer_mem

// ### verif/pump_cmd_props.sv
`timescale 1ns/100ps
module pump_cmd_props
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic plunger_stall,
	input wire logic plunger_up_r,
	input wire logic plunger_back_go_r,
	input wire logic [1:0] home_force_r,
	input wire logic [5:0] home_speed_code_r,
	input wire logic [9:0] home_pps_r,
	input wire logic [12:0] backlash_steps_r,
	input wire logic [1:0] step_mode_r,
	input wire logic [9:0] rate_limit_r,
	input wire logic nv_we_r
);
	import pump_cmd_pkg::*;
	// ************************************************************
	// properties
	// ************************************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence stall_hit;
		plunger_up_r && plunger_stall;
	endsequence
	sequence back_off;
		!plunger_up_r && plunger_back_go_r;
	endsequence
	a_stall_back_off: assert property (stall_hit |=> back_off)
		else $error("no back-off after stall");
	a_pready_prompt: assert property (psel && !penable |=> pready)
		else $error("no answer in first access cycle");
	a_pready_single: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_slverr_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_fine_rate_limit: assert property ($changed(step_mode_r) |-> ##[0:1]
		rate_limit_r == ((step_mode_r == MODE_FINE) ? FINE_RATE_LIMIT : 10'h000))
		else $error("rate limit does not follow step mode");
	a_default_pps: assert property (home_speed_code_r == 6'h00 |-> ##[0:1] home_pps_r == INIT_DEFAULT_PPS)
		else $error("default speed not 500");
	a_force_range: assert property (home_force_r != 2'h3)
		else $error("force code out of range");
	a_backlash_normal: assert property (step_mode_r == 2'h0 |-> ##[0:1] backlash_steps_r <= 13'h0320)
		else $error("backlash above normal limit");
	a_nv_strobe_pulse: assert property (nv_we_r |=> !nv_we_r)
		else $error("nv strobe longer than one cycle");
endmodule : pump_cmd_props

// ### verif/drive_model.sv
`timescale 1ns/100ps
// plunger and valve drives; lag sets how slowly they answer
module drive_model
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] lag,
	input wire logic plunger_up_r,
	input wire logic plunger_back_go_r,
	input wire logic valve_home_go_r,
	output logic plunger_stall,
	output logic motion_done
);
	logic [3:0] up_cnt;
	logic [3:0] move_cnt;
	logic moving;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			up_cnt <= 4'h0;
			plunger_stall <= 1'b0;
		end
		else if (!plunger_up_r)
		begin
			up_cnt <= 4'h0;
			plunger_stall <= 1'b0;
		end
		else if (up_cnt == lag)
			plunger_stall <= 1'b1;
		else
			up_cnt <= up_cnt + 4'h1;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			moving <= 1'b0;
			move_cnt <= 4'h0;
			motion_done <= 1'b0;
		end
		else
		begin
			motion_done <= 1'b0;
			if (plunger_back_go_r || valve_home_go_r)
			begin
				moving <= 1'b1;
				move_cnt <= 4'h0;
			end
			else if (moving && move_cnt == lag)
			begin
				moving <= 1'b0;
				motion_done <= 1'b1;
			end
			else
				move_cnt <= move_cnt + 4'h1;
		end
	end
endmodule : drive_model

// ### verif/pump_command_interpreter_bench.sv
`timescale 1ns/100ps
module pump_command_interpreter_bench;
	import pump_cmd_pkg::*;
	typedef struct {string cmd; logic [7:0] addr; logic [31:0] mask; logic [31:0] exp;} row_s;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, plunger_stall, motion_done;
	logic [7:0] paddr, nv_wdata_r, nv_d;
	logic [31:0] pwdata, prdata, rd_v;
	logic [3:0] valve_port_count, lag, in_port_r, out_port_r;
	logic plunger_up_r, plunger_back_go_r, valve_home_go_r, position_zero_r, valve_ccw_r;
	logic nv_we_r, busy_r, slv_err, zero_seen;
	logic [1:0] home_force_r, step_mode_r;
	logic [5:0] home_speed_code_r;
	logic [9:0] home_pps_r, rate_limit_r;
	logic [12:0] backoff_steps_r, backlash_steps_r;
	logic [4:0] nv_addr_r, nv_a;
	int err_total, comparisons, cycles;
	row_s rows[13] = '{
		'{"N1R", OFF_SETTINGS, 32'h03ff_0003, 32'h02ee_0001},
		'{"N2R", OFF_SETTINGS, 32'h03ff_0003, 32'h0000_0002},
		'{"N1K6400R", OFF_STEPS, 32'h0000_1fff, 32'h0000_1900},
		'{"N0K801R", OFF_STEPS, 32'h0000_1fff, 32'h0000_000c},
		'{"K801R", OFF_STATUS, 32'h0000_000f, 32'h0000_0003},
		'{"K5N0R", OFF_STEPS, 32'h0000_1fff, 32'h0000_000c},
		'{"@R", OFF_STATUS, 32'h0000_000f, 32'h0000_0002},
		'{"k6400R", OFF_STATUS, 32'h0000_000f, 32'h0000_0003},
		'{"k10R", OFF_STEPS, 32'h1fff_0000, 32'h000a_0000},
		'{"U47R", OFF_SETTINGS, 32'h0000_000b, 32'h0000_0008},
		'{"U30R", OFF_SETTINGS, 32'h0000_0004, 32'h0000_0004},
		'{"U31R", OFF_SETTINGS, 32'h0000_0004, 32'h0000_0000},
		'{"U99R", OFF_STATUS, 32'h0000_000f, 32'h0000_0003}};
	pump_command_interpreter i_pump_command_interpreter (.*);
	drive_model i_drive_model (.*);
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task test_done();
		$display("comparisons %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// one idle cycle after each transfer keeps psel from being driven twice in a step
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
		begin
			@(posedge pclk);
		end
		rd_v = prdata;
		slv_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task send(input string s);
		foreach (s[i])
			apb(1'b1, OFF_CHAR, {24'h0, s[i]});
		apb(1'b1, OFF_CHAR, {24'h0, CH_CR});
	endtask : send
	task wait_idle();
		repeat (3) @(posedge pclk);
		while (busy_r !== 1'b0)
		begin
			@(posedge pclk);
		end
	endtask : wait_idle
	task reg_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		check($sformatf("reg %h", a), rd_v & m, e);
	endtask : reg_chk
	always @(posedge pclk)
	begin
		cycles++;
		if (nv_we_r === 1'b1)
		begin
			nv_a <= nv_addr_r;
			nv_d <= nv_wdata_r;
		end
		if (position_zero_r === 1'b1)
			zero_seen <= 1'b1;
		if (cycles == 30000)
		begin
			err_total++;
			$display("Error timeout expected done seen hang");
			test_done();
		end
	end
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, zero_seen} = '0;
		valve_port_count = 4'h6;
		lag = 4'h2;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (rows[i])
		begin
			send(rows[i].cmd);
			wait_idle();
			reg_chk(rows[i].addr, rows[i].mask, rows[i].exp);
		end
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		reg_chk(OFF_STATUS, 32'hffff_ffff, 32'h0030_0060);
		reg_chk(OFF_STEPS, 32'hffff_ffff, 32'h0000_000c);
		reg_chk(OFF_PORTS, 32'hffff_ffff, 32'h01f4_0001);
		apb(1'b0, 8'h14, 32'h0000_0000);
		check("unmapped err", {31'h0, slv_err}, 32'h0000_0001);
		send("N1");
		wait_idle();
		reg_chk(OFF_SETTINGS, 32'h0000_0003, 32'h0000_0000);
		reg_chk(OFF_STATUS, 32'h0000_0200, 32'h0000_0200);
		send(">3,7R");
		wait_idle();
		check("nv user", {19'h0, nv_a, nv_d}, 32'h0000_0307);
		send("U41R");
		wait_idle();
		check("nv cfg", {19'h0, nv_a, nv_d}, 32'h0000_1029);
		lag <= 4'hf;
		send("k10R");
		wait_idle();
		send("Z1,2,3R");
		send("N2R");
		wait_idle();
		reg_chk(OFF_STATUS, 32'h0000_000f, 32'h0000_000f);
		reg_chk(OFF_SETTINGS, 32'h0000_0073, 32'h0000_0020);
		reg_chk(OFF_PORTS, 32'h03ff_3fff, 32'h01f4_0032);
		check("zeroed", {31'h0, zero_seen}, 32'h0000_0001);
		send("Q");
		wait_idle();
		reg_chk(OFF_STATUS, 32'h0000_000f, 32'h0000_000f);
		send("ZR");
		send("T");
		reg_chk(OFF_STATUS, 32'h0000_0020, 32'h0000_0020);
		lag <= 4'h0;
		send("Y10,0,0R");
		wait_idle();
		reg_chk(OFF_PORTS, 32'h03ff_3fff, 32'h0000_0a61);
		reg_chk(OFF_SETTINGS, 32'h0000_0010, 32'h0000_0010);
		reg_chk(OFF_STEPS, 32'h1fff_1fff, 32'h000a_000c);
		check("backoff", {19'h0, backoff_steps_r}, 32'h0000_000a);
		test_done();
	end
endmodule : pump_command_interpreter_bench
bind pump_command_interpreter pump_cmd_props i_pump_cmd_props (.pclk, .presetn, .psel, .penable, .pready,
	.pslverr, .plunger_stall, .plunger_up_r, .plunger_back_go_r, .home_force_r, .home_speed_code_r,
	.home_pps_r, .backlash_steps_r, .step_mode_r, .rate_limit_r, .nv_we_r);
